// ### hw/dpd_top.sv
// Protection, diagnosis and register control of a twelve-channel output driver.
//
// Behaviour
// - Undervoltage delay expiry sets supply fail, disables outputs.
// - Short timer select picks undervoltage delay length.
// - Outputs return at once when supply recovers.
// - Supply fail flag stays until clear request.
// - Open-load mode enables test currents on switches.
// - Sensed open load sets channel status bit.
// - Switched-on channel has open-load detection disabled.
// - Heat warning set above, cleared below thresholds.
// - Chip select fall shows heat warning on data out.
// - Aborted frame leaves the input register unchanged.
// - Thermal shutdown disables outputs, status reads all ones.
// - Shutdown released when cool and clear written.
// - Overcurrent regulates current and starts short timer.
// - Persistent short past delay disables channel, flags.
// - Heat warning during short disables channel immediately.
// - Clear request resets short flag, re-enables channels.
// - Run bit low or standby pin low stops outputs.
// - Run bit and standby pin both high restore outputs.
// - Input bit 14 selects 12 ms or 1.5 ms.
// - Output word places heat, channels, short, supply bits.
// - Output bit 14 reports standby state.
// - Reset presets run, select, open-load bits high.
`timescale 1ns/1ps
`default_nettype none
module dpd_top
  import dpd_pkg::*;
#(
  parameter int OSC_DIV = dpd_pkg::OSC_DIV_DEF
)
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic ce,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic sdi,
  input wire logic supply_low,
  input wire logic temp_above_warn,
  input wire logic temp_below_warn,
  input wire logic temp_above_off,
  input wire logic temp_below_on,
  input wire logic hw_standby_pin,
  input wire logic [dpd_pkg::CH_N-1:0] overcurrent,
  input wire logic [dpd_pkg::CH_N-1:0] open_load_sense,
  output logic sdo,
  output logic sdo_oe,
  output logic [dpd_pkg::CH_N-1:0] drive_on,
  output logic [dpd_pkg::CH_N-1:0] test_current_en,
  output logic [dpd_pkg::CH_N-1:0] current_limit_en,
  output logic heat_warning,
  output logic short_flag,
  output logic supply_fail_flag,
  output logic standby
);
  import dpd_pkg::*;

  typedef struct packed {
    logic [AIN_W-1:0] s1;
    logic [AIN_W-1:0] s2;
    logic cs_prev;
    logic [WORD_W-1:0] in_reg;
    logic [WORD_W-1:0] snap;
    logic heat;
    logic tsd;
    logic tsd_clr;
    logic supply_fail;
    logic uv_off;
    logic [TMR_W-1:0] uv_cnt;
    logic [DIV_W-1:0] div;
    logic tick;
    logic [CH_N-1:0][TMR_W-1:0] sc_cnt;
    logic [CH_N-1:0] sc_off;
    logic short_flag;
    logic [CH_N-1:0] drv;
    logic [CH_N-1:0] test_en;
    logic [CH_N-1:0] limit;
    logic sdo;
    logic sdo_oe;
    logic standby;
  } dpd_sys_t;

  dpd_sys_t q;
  dpd_sys_t d;

  logic link_bit;
  logic link_go;
  logic [CNT_W-1:0] link_cnt;
  logic [WORD_W-1:0] link_rx;

  logic cs_s;
  logic cs_fall_w;
  logic cs_rise_w;
  logic commit_w;
  logic clr_w;
  logic uv_s;
  logic uv_expire_w;
  logic standby_w;
  logic short_set_w;
  logic [TMR_W-1:0] sel_ticks;
  logic [CH_N-1:0] oc_s;
  logic [CH_N-1:0] ol_s;
  logic [WORD_W-1:0] status_w;

  // Open-load sensing applies to a channel commanded off while open-load mode is on.
  function automatic logic ol_active(input logic [WORD_W-1:0] w, input int c);
    return !w[IN_OLC_N] && !w[IN_CH0 + c];
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Link side shift logic.
  dpd_link dpd_link_inst (
    .sclk(sclk),
    .cs_n(cs_n),
    .sdi(sdi),
    .snap(q.snap),
    .bit_out(link_bit),
    .started(link_go),
    .cnt(link_cnt),
    .rx(link_rx)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Next state.
  always_comb
  begin
    d = q;
    d.s1 = {open_load_sense, overcurrent, link_go, link_bit, cs_n, hw_standby_pin,
            temp_below_on, temp_above_off, temp_below_warn, temp_above_warn, supply_low};
    d.s2 = q.s1;

    cs_s = q.s2[S_CS_N];
    uv_s = q.s2[S_SUPPLY_LOW];
    oc_s = q.s2[S_OC0 +: CH_N];
    ol_s = q.s2[S_OL0 +: CH_N];
    d.cs_prev = cs_s;
    cs_fall_w = q.cs_prev && !cs_s;
    cs_rise_w = !q.cs_prev && cs_s;
    commit_w = cs_rise_w && (link_cnt == FRAME_BITS);
    clr_w = commit_w && link_rx[IN_CLR];
    if (commit_w)
    begin
      d.in_reg = {link_rx[WORD_W-1:1], 1'b0};
    end
    sel_ticks = q.in_reg[IN_SEL] ? LONG_TICKS : SHORT_TICKS;

    // Oscillator tick that paces every delay timer.
    d.tick = 1'b0;
    if (q.div == DIV_W'(OSC_DIV - 1))
    begin
      d.div = '0;
      d.tick = 1'b1;
    end
    else
    begin
      d.div = q.div + 12'h001;
    end

    // Temperature warning with hysteresis.
    if (q.s2[S_WARN_SET])
    begin
      d.heat = 1'b1;
    end
    else if (q.s2[S_WARN_RESET])
    begin
      d.heat = 1'b0;
    end

    // Thermal shutdown and its release.
    if (q.s2[S_TEMP_OFF])
    begin
      d.tsd = 1'b1;
      d.tsd_clr = 1'b0;
    end
    else if (q.tsd)
    begin
      if (clr_w)
      begin
        d.tsd_clr = 1'b1;
      end
      if (q.s2[S_TEMP_ON] && (q.tsd_clr || clr_w))
      begin
        d.tsd = 1'b0;
        d.tsd_clr = 1'b0;
      end
    end

    // Supply undervoltage timer.
    uv_expire_w = uv_s && (q.uv_cnt >= sel_ticks);
    if (uv_s)
    begin
      if (q.tick && !uv_expire_w)
      begin
        d.uv_cnt = q.uv_cnt + 9'h001;
      end
      if (uv_expire_w)
      begin
        d.uv_off = 1'b1;
      end
    end
    else
    begin
      d.uv_cnt = '0;
      d.uv_off = 1'b0;
    end
    d.supply_fail = uv_expire_w || (q.supply_fail && !clr_w);

    // Per-channel short-circuit timers; a set in the clear cycle wins.
    short_set_w = 1'b0;
    for (int c = 0; c < CH_N; c++)
    begin
      if (clr_w)
      begin
        d.sc_off[c] = 1'b0;
      end
      if (oc_s[c] && q.drv[c])
      begin
        if (q.tick && (q.sc_cnt[c] < sel_ticks))
        begin
          d.sc_cnt[c] = q.sc_cnt[c] + 9'h001;
        end
        if ((q.sc_cnt[c] >= sel_ticks) || q.heat)
        begin
          d.sc_off[c] = 1'b1;
          short_set_w = 1'b1;
        end
      end
      else
      begin
        d.sc_cnt[c] = '0;
      end
    end
    d.short_flag = short_set_w || (q.short_flag && !clr_w);

    // Output stage control.
    standby_w = !d.in_reg[IN_RUN] || !q.s2[S_STBY_PIN];
    d.standby = standby_w;
    for (int c = 0; c < CH_N; c++)
    begin
      d.drv[c] = d.in_reg[IN_CH0 + c] && !standby_w && !d.uv_off && !d.tsd && !d.sc_off[c];
      d.test_en[c] = ol_active(d.in_reg, c);
    end
    d.limit = oc_s & d.drv;

    // Status word as the controller reads it.
    status_w[OUT_HEAT] = q.heat;
    for (int c = 0; c < CH_N; c++)
    begin
      if (ol_active(q.in_reg, c))
      begin
        status_w[OUT_CH0 + c] = ol_s[c];
      end
      else
      begin
        status_w[OUT_CH0 + c] = q.drv[c];
      end
    end
    status_w[OUT_SHORT] = q.short_flag;
    status_w[OUT_STBY] = q.standby;
    status_w[OUT_SUPPLY] = q.supply_fail;
    if (q.tsd)
    begin
      status_w = OUT_TSD;
    end
    if (cs_fall_w)
    begin
      d.snap = status_w;
    end

    // Data out: the first bit is shown as soon as chip select falls.
    d.sdo_oe = !cs_s;
    if (cs_s)
    begin
      d.sdo = 1'b0;
    end
    else if (q.s2[S_LINK_GO])
    begin
      d.sdo = q.s2[S_LINK_BIT];
    end
    else
    begin
      d.sdo = status_w[OUT_HEAT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register.
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      q <= '0;
      q.s1[S_CS_N] <= 1'b1;
      q.s2[S_CS_N] <= 1'b1;
      q.s1[S_STBY_PIN] <= 1'b1;
      q.s2[S_STBY_PIN] <= 1'b1;
      q.cs_prev <= 1'b1;
      q.in_reg <= IN_RESET;
    end
    else if (ce)
    begin
      q <= d;
    end
  end

  assign sdo = q.sdo;
  assign sdo_oe = q.sdo_oe;
  assign drive_on = q.drv;
  assign test_current_en = q.test_en;
  assign current_limit_en = q.limit;
  assign heat_warning = q.heat;
  assign short_flag = q.short_flag;
  assign supply_fail_flag = q.supply_fail;
  assign standby = q.standby;

  ////////////////////////////////////////////////////////////////////////////
  // Checks.
  uv_flag_set_a: assert property (@(posedge clk_sys) disable iff (rst)
    ce && uv_expire_w |=> q.supply_fail && q.uv_off && (q.drv == '0))
    else $error("Supply fail not raised after undervoltage delay.");

  uv_release_a: assert property (@(posedge clk_sys) disable iff (rst)
    ce && q.uv_off && !uv_s |=> !q.uv_off)
    else $error("Outputs not released after supply recovery.");

  flag_hold_a: assert property (@(posedge clk_sys) disable iff (rst)
    q.supply_fail && !(ce && clr_w) |=> q.supply_fail)
    else $error("Supply fail flag dropped without clear.");

  olc_test_a: assert property (@(posedge clk_sys) disable iff (rst)
    q.in_reg[IN_OLC_N] |-> (q.test_en == '0))
    else $error("Test current on outside open-load mode.");

  tsd_drive_a: assert property (@(posedge clk_sys) disable iff (rst)
    q.tsd |-> (q.drv == '0))
    else $error("Output driven during thermal shutdown.");

  tsd_keep_a: assert property (@(posedge clk_sys) disable iff (rst)
    q.tsd && !q.s2[S_TEMP_ON] |=> q.tsd)
    else $error("Thermal shutdown released while hot.");

  short_fast_a: assert property (@(posedge clk_sys) disable iff (rst)
    ce && q.heat && |(oc_s & q.drv) |=> q.short_flag ##1 !(|(oc_s & q.drv)) || !ce)
    else $error("Short not cut at once under heat warning.");

  short_clr_a: assert property (@(posedge clk_sys) disable iff (rst)
    ce && clr_w && !short_set_w |=> !q.short_flag && (q.sc_off == '0))
    else $error("Clear request did not reset short state.");

  standby_off_a: assert property (@(posedge clk_sys) disable iff (rst)
    !q.in_reg[IN_RUN] |-> (q.drv == '0) && q.standby)
    else $error("Output driven while run bit low.");

  abort_keep_a: assert property (@(posedge clk_sys) disable iff (rst)
    ce && cs_rise_w && (link_cnt != FRAME_BITS) |=> $stable(q.in_reg))
    else $error("Aborted frame changed the input register.");

  heat_out_a: assert property (@(posedge clk_sys) disable iff (rst)
    ce && cs_fall_w |=> q.sdo_oe && (q.sdo == $past(status_w[OUT_HEAT])))
    else $error("Heat warning not shown after chip select fall.");
endmodule // dpd_top
`default_nettype wire

// ### shared/dpd_pkg.sv
// Constants shared by the driver protection and diagnosis logic.
`default_nettype none
package dpd_pkg;
  localparam int WORD_W = 16;
  localparam int CH_N = 12;
  localparam int CNT_W = 5;
  localparam logic [CNT_W-1:0] FRAME_BITS = 5'h10;
  // Input word layout.
  localparam int IN_CLR = 0;
  localparam int IN_CH0 = 1;
  localparam int IN_OLC_N = 13;
  localparam int IN_SEL = 14;
  localparam int IN_RUN = 15;
  localparam logic [WORD_W-1:0] IN_RESET = 16'he000;
  // Output word layout.
  localparam int OUT_HEAT = 0;
  localparam int OUT_CH0 = 1;
  localparam int OUT_SHORT = 13;
  localparam int OUT_STBY = 14;
  localparam int OUT_SUPPLY = 15;
  localparam logic [WORD_W-1:0] OUT_TSD = 16'hffff;
  // Synchronised input vector layout.
  localparam int S_SUPPLY_LOW = 0;
  localparam int S_WARN_SET = 1;
  localparam int S_WARN_RESET = 2;
  localparam int S_TEMP_OFF = 3;
  localparam int S_TEMP_ON = 4;
  localparam int S_STBY_PIN = 5;
  localparam int S_CS_N = 6;
  localparam int S_LINK_BIT = 7;
  localparam int S_LINK_GO = 8;
  localparam int S_OC0 = 9;
  localparam int S_OL0 = 21;
  localparam int AIN_W = 33;
  // Timing.
  localparam int SYS_HZ = 100_000_000;
  localparam int OSC_HZ = 32_000;
  localparam int OSC_DIV_DEF = SYS_HZ / OSC_HZ;
  localparam int DIV_W = 12;
  localparam int TMR_W = 9;
  localparam int LONG_US = 12000;
  localparam int SHORT_US = 1500;
  localparam logic [TMR_W-1:0] LONG_TICKS = TMR_W'((LONG_US * OSC_HZ + 999_999) / 1_000_000);
  localparam logic [TMR_W-1:0] SHORT_TICKS = TMR_W'((SHORT_US * OSC_HZ + 999_999) / 1_000_000);
endpackage
`default_nettype wire

// ### hw/dpd_link.sv
// Serial shift logic running on the link clock; chip select high clears its start and output bits.
`timescale 1ns/1ps
`default_nettype none
module dpd_link
  import dpd_pkg::*;
(
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic sdi,
  input wire logic [dpd_pkg::WORD_W-1:0] snap,
  output logic bit_out,
  output logic started,
  output logic [dpd_pkg::CNT_W-1:0] cnt,
  output logic [dpd_pkg::WORD_W-1:0] rx
);
  import dpd_pkg::*;

  typedef struct packed {
    logic started;
    logic out;
    logic [CNT_W-1:0] cnt;
    logic [WORD_W-1:0] rx;
  } dpd_link_t;

  dpd_link_t q;
  dpd_link_t d;

  ////////////////////////////////////////////////////////////////////////////
  // Bits are taken least significant first; the next status bit follows.
  always_comb
  begin
    d = q;
    d.started = 1'b1;
    d.rx = {sdi, q.rx[WORD_W-1:1]};
    if (!q.started)
    begin
      d.cnt = 5'h01;
    end
    else if (q.cnt != 5'h1f)
    begin
      d.cnt = q.cnt + 5'h01;
    end
    d.out = (d.cnt < FRAME_BITS) ? snap[d.cnt[3:0]] : 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Chip select high ends the frame; the received word and count are kept.
  always_ff @(posedge sclk or posedge cs_n)
  begin
    if (cs_n)
    begin
      q.started <= 1'b0;
      q.out <= 1'b0;
    end
    else
    begin
      q <= d;
    end
  end

  assign bit_out = q.out;
  assign started = q.started;
  assign cnt = q.cnt;
  assign rx = q.rx;
endmodule // dpd_link
`default_nettype wire

// ### bench/dpd_host.sv
// Serial controller model that runs frames on the link.
`timescale 1ns/1ps
`default_nettype none
module dpd_host
(
  output logic sclk,
  output logic cs_n,
  output logic sdi,
  input wire logic sdo
);
  localparam int HALF = 250;
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    sclk = 1'b0;
    cs_n = 1'b1;
    sdi = 1'b0;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // Runs n clock pulses; fewer than sixteen abort the frame.
  task automatic xfer(input logic [15:0] w, input int n, output logic [15:0] r);
    r = 16'h0000;
    sdi = w[0];
    cs_n = 1'b0;
    #HALF;
    r[0] = sdo;
    for (int k = 0; k < n; k++)
    begin
      sclk = 1'b1;
      #HALF;
      sclk = 1'b0;
      if (k < 15)
      begin
        r[k+1] = sdo;
        sdi = w[k+1];
      end
      #HALF;
    end
    cs_n = 1'b1;
    sdi = ~sdi;
    #HALF;
  endtask
endmodule // dpd_host
`default_nettype wire

// ### bench/dpd_top_tb.sv
// Self-checking bench for the protection and diagnosis block.
`timescale 1ns/1ps
`default_nettype none
module dpd_top_tb;
  import dpd_pkg::*;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic sclk, cs_n, sdi, sdo, oe, heat, shrt, sfail, stby;
  logic supply_low = 1'b0;
  logic t_aw = 1'b0;
  logic t_bw = 1'b1;
  logic t_ao = 1'b0;
  logic t_bo = 1'b1;
  logic pin = 1'b1;
  logic [CH_N-1:0] oc = '0;
  logic [CH_N-1:0] ol = '0;
  logic [CH_N-1:0] drv, tst, lim;
  logic [15:0] got;
  int errors = 0;
  int total_checks = 0;
  always #5 clk_sys = ~clk_sys;
  ////////////////////////////////////////////////////////////////////////////////
  dpd_top #(.OSC_DIV(4)) dpd_top_inst (.clk_sys(clk_sys), .rst(rst), .ce(1'b1), .sclk(sclk), .cs_n(cs_n),
    .sdi(sdi), .supply_low(supply_low), .temp_above_warn(t_aw), .temp_below_warn(t_bw),
    .temp_above_off(t_ao), .temp_below_on(t_bo), .hw_standby_pin(pin), .overcurrent(oc),
    .open_load_sense(ol), .sdo(sdo), .sdo_oe(oe), .drive_on(drv), .test_current_en(tst),
    .current_limit_en(lim), .heat_warning(heat), .short_flag(shrt), .supply_fail_flag(sfail), .standby(stby));
  dpd_host dpd_host_inst (.sclk(sclk), .cs_n(cs_n), .sdi(sdi), .sdo(sdo));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(negedge clk_sys);
  endtask
  // Sends a full frame and lets the update land.
  task automatic frame(input logic [15:0] w);
    dpd_host_inst.xfer(w, 16, got);
    wt(8);
    chk({oe, sdo}, 16'h0000);
  endtask
  always @(negedge sclk)
    if (!cs_n)
      chk(oe, 1'b1);
  task automatic final_report;
    $display("checks %0d, mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    #400_000;
    errors++;
    final_report;
  end
  initial
  begin
    wt(4);
    rst = 1'b0;
    wt(3);
    chk({drv, heat, shrt, sfail, stby}, 16'h0000);
    chk({tst, oe, sdo}, 16'h0000);
    frame(16'he006);
    chk(got, 16'h0000);
    chk(drv, 16'h0003);
    frame(16'he006);
    chk(got, 16'h0006);
    pin = 1'b0;
    wt(8);
    chk({drv, stby}, {12'h000, 1'b1});
    frame(16'he006);
    chk(got[14], 1'b1);
    pin = 1'b1;
    wt(8);
    chk({drv, stby}, {12'h003, 1'b0});
    frame(16'h6006);
    chk({drv, stby}, {12'h000, 1'b1});
    frame(16'he006);
    chk({drv, stby}, {12'h003, 1'b0});
    ol = 12'h004;
    frame(16'hc006);
    chk(tst, 16'h0ffc);
    frame(16'hc006);
    chk(got, 16'h000e);
    ol = 12'h000;
    frame(16'he006);
    t_aw = 1'b1;
    t_bw = 1'b0;
    wt(8);
    chk(heat, 1'b1);
    t_aw = 1'b0;
    dpd_host_inst.xfer(16'h0000, 5, got);
    wt(8);
    chk(got[0], 1'b1);
    chk({drv, heat}, {12'h003, 1'b1});
    oc = 12'h002;
    wt(8);
    chk({drv, shrt}, {12'h001, 1'b1});
    oc = 12'h000;
    t_bw = 1'b1;
    wt(8);
    chk(heat, 1'b0);
    frame(16'ha007);
    chk({drv, shrt}, {12'h003, 1'b0});
    oc = 12'h001;
    wt(6);
    chk(lim, 16'h0001);
    wt(160);
    chk({drv, shrt}, {12'h003, 1'b0});
    wt(60);
    chk({drv, shrt}, {12'h002, 1'b1});
    oc = 12'h000;
    frame(16'he007);
    chk({drv, shrt}, {12'h003, 1'b0});
    supply_low = 1'b1;
    wt(1400);
    chk({drv, sfail}, {12'h003, 1'b0});
    wt(200);
    chk({drv, sfail}, {12'h000, 1'b1});
    supply_low = 1'b0;
    wt(8);
    chk({drv, sfail}, {12'h003, 1'b1});
    frame(16'he006);
    chk(got[15], 1'b1);
    frame(16'he007);
    chk(sfail, 1'b0);
    t_ao = 1'b1;
    t_bo = 1'b0;
    wt(8);
    chk(drv, 16'h0000);
    frame(16'he006);
    chk(got, 16'hffff);
    t_ao = 1'b0;
    frame(16'he007);
    chk(drv, 16'h0000);
    t_bo = 1'b1;
    wt(8);
    chk(drv, 16'h0003);
    final_report;
  end
endmodule // dpd_top_tb
`default_nettype wire
